/* File: verilog/pio_ports.sv */
// Three parallel I/O ports with latches and directions, pullups on first and third
//
// Summary of operation
// [R1] Per-pin latch, kept unchanged by reset
// [R2] Direction 1 drives latch, 0 is input
// [R3] Reset clears all direction bits
// [R4] First port read: latch if output, else pin
// [R5] Second port read uses same selection
// [R6] Third port read uses same selection
// [R7] Data writes always update latch only
// [R8] Direction registers read back last write
// [R9] First port pullup per pin when input
// [R10] Pullup off whenever pin is output
// [R11] No pullup: pin stays high impedance
// [R12] Third port has pullups like first
// [R13] Third port has seven pins only
// [R14] Keypad enable turns pin into interrupt input
// [R15] Selected converter channel forced analog input
// [R16] Software loads latch before setting output
// [R17] Software avoids digital reads of analog pins
// [R18] Pullups reset zero, third top bit zero
// [R19] Pin levels synchronised before read
//
// Added by the designer: the plain strobed port.
`include "pio_defines.svh"

module pio_ports (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_in,
    // Register port
    input  wire logic [`PIO_AW-1:0]    addr_in,
    input  wire logic [`PIO_DW-1:0]    wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic      [`PIO_DW-1:0]    rdata_out,
    // First port pins
    input  wire logic [`PIO_WA-1:0]    pa_pin_in,
    output logic      [`PIO_WA-1:0]    pa_pin_out,
    output logic      [`PIO_WA-1:0]    pa_pin_oe_out,
    output logic      [`PIO_WA-1:0]    pa_pullup_out,
    // Second port pins
    input  wire logic [`PIO_WB-1:0]    pb_pin_in,
    output logic      [`PIO_WB-1:0]    pb_pin_out,
    output logic      [`PIO_WB-1:0]    pb_pin_oe_out,
    output logic      [`PIO_WB-1:0]    pb_pullup_out,
    // Third port pins
    input  wire logic [`PIO_WC-1:0]    pc_pin_in,
    output logic      [`PIO_WC-1:0]    pc_pin_out,
    output logic      [`PIO_WC-1:0]    pc_pin_oe_out,
    output logic      [`PIO_WC-1:0]    pc_pullup_out,
    // Keypad interrupt unit
    input  wire logic [`PIO_WA-1:0]    keypad_irq_enables_in,
    output logic      [`PIO_WA-1:0]    keypad_inputs_out,
    // Converter channel select
    input  wire logic [`PIO_ADC_W-1:0] adc_channel_in,
    output logic      [`PIO_WB-1:0]    analog_select_out
);

    // =================================================================
    // Storage
    logic [`PIO_DW-1:0]  first_port_latch;
    logic [`PIO_DW-1:0]  second_port_latch;
    logic [`PIO_DW-1:0]  third_port_latch;
    pio_pkg::pio_cfg_s   cfg_a;
    pio_pkg::pio_cfg_s   cfg_b;
    pio_pkg::pio_cfg_s   cfg_c;
    pio_pkg::pio_req_s   req;
    logic [`PIO_WA-1:0]  pa_sync;
    logic [`PIO_WB-1:0]  pb_sync;
    logic [`PIO_WC-1:0]  pc_sync;
    logic [`PIO_DW-1:0]  pc_sync_w;
    logic [`PIO_WB-1:0]  next_analog;
    logic [`PIO_DW-1:0]  next_rdata;

    // =================================================================
    // Address decode into one select code
    always_comb begin
        req.wdata = wdata_in;
        req.wr    = wr_in;
        req.rd    = rd_in;
        case (addr_in)
            `PIO_OFF_A_DATA: req.sel = pio_pkg::pio_sel_a_data;
            `PIO_OFF_B_DATA: req.sel = pio_pkg::pio_sel_b_data;
            `PIO_OFF_C_DATA: req.sel = pio_pkg::pio_sel_c_data;
            `PIO_OFF_A_DIR:  req.sel = pio_pkg::pio_sel_a_dir;
            `PIO_OFF_B_DIR:  req.sel = pio_pkg::pio_sel_b_dir;
            `PIO_OFF_C_DIR:  req.sel = pio_pkg::pio_sel_c_dir;
            `PIO_OFF_A_PUE:  req.sel = pio_pkg::pio_sel_a_pue;
            `PIO_OFF_C_PUE:  req.sel = pio_pkg::pio_sel_c_pue;
            default:         req.sel = pio_pkg::pio_sel_none;
        endcase
    end

    // =================================================================
    // Data latches: no reset, so output values survive a reset
    always_ff @(posedge clk_sys_in) begin
        if (req.wr) begin
            case (req.sel)
                pio_pkg::pio_sel_a_data: begin
                    first_port_latch <= req.wdata;               // R1 R7
                end
                pio_pkg::pio_sel_b_data: begin
                    second_port_latch <= req.wdata;              // R7
                end
                pio_pkg::pio_sel_c_data: begin
                    third_port_latch <= req.wdata & `PIO_C_MASK; // R13
                end
                default: begin
                end
            endcase
        end
    end

    // =================================================================
    // Direction registers, cleared so all pins start as inputs
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_a.dir <= `PIO_ZERO;                              // R3
            cfg_b.dir <= `PIO_ZERO;
            cfg_c.dir <= `PIO_ZERO;
        end else if (req.wr) begin
            case (req.sel)
                pio_pkg::pio_sel_a_dir: cfg_a.dir <= req.wdata;  // R8
                pio_pkg::pio_sel_b_dir: cfg_b.dir <= req.wdata;
                pio_pkg::pio_sel_c_dir: begin
                    cfg_c.dir <= req.wdata & `PIO_C_MASK;        // R13
                end
                default: begin
                end
            endcase
        end
    end

    // =================================================================
    // Pullup enables; second port has none, so its field stays zero
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_a.pue <= `PIO_ZERO;                              // R18
            cfg_b.pue <= `PIO_ZERO;                              // R11
            cfg_c.pue <= `PIO_ZERO;
        end else if (req.wr) begin
            case (req.sel)
                pio_pkg::pio_sel_a_pue: cfg_a.pue <= req.wdata;  // R9
                pio_pkg::pio_sel_c_pue: begin
                    cfg_c.pue <= req.wdata & `PIO_C_MASK;        // R12
                end
                default: begin
                end
            endcase
        end
    end

    // =================================================================
    // Pin synchronisers; reads see levels two cycles old
    pio_sync #(
        .WIDTH (`PIO_WA)
    ) u_sync_a (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .din_in     (pa_pin_in),
        .dout_out   (pa_sync)
    );

    pio_sync #(
        .WIDTH (`PIO_WB)
    ) u_sync_b (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .din_in     (pb_pin_in),
        .dout_out   (pb_sync)
    );

    pio_sync #(
        .WIDTH (`PIO_WC)
    ) u_sync_c (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .din_in     (pc_pin_in),
        .dout_out   (pc_sync)
    );

    assign pc_sync_w = {1'b0, pc_sync};

    // =================================================================
    // Read mux: per bit, latch for outputs and pin for inputs
    always_comb begin
        next_rdata = `PIO_ZERO;
        case (req.sel)
            pio_pkg::pio_sel_a_data: begin
                next_rdata = (first_port_latch & cfg_a.dir)
                           | (pa_sync & ~cfg_a.dir);             // R4 R19
            end
            pio_pkg::pio_sel_b_data: begin
                next_rdata = (second_port_latch & cfg_b.dir)
                           | (pb_sync & ~cfg_b.dir);             // R5
            end
            pio_pkg::pio_sel_c_data: begin
                next_rdata = (third_port_latch & cfg_c.dir)
                           | (pc_sync_w & ~cfg_c.dir);           // R6 R18
            end
            pio_pkg::pio_sel_a_dir: next_rdata = cfg_a.dir;      // R8
            pio_pkg::pio_sel_b_dir: next_rdata = cfg_b.dir;
            pio_pkg::pio_sel_c_dir: next_rdata = cfg_c.dir;
            pio_pkg::pio_sel_a_pue: next_rdata = cfg_a.pue;
            pio_pkg::pio_sel_c_pue: next_rdata = cfg_c.pue;
            default:                next_rdata = `PIO_ZERO;
        endcase
    end

    // =================================================================
    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_out <= `PIO_ZERO;
        end else if (req.rd) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= `PIO_ZERO;
        end
    end

    // =================================================================
    // Converter channel decode; channels past the second port pick none
    always_comb begin
        next_analog = `PIO_ZERO;
        if (adc_channel_in < `PIO_ADC_W'(`PIO_WB)) begin
            next_analog = `PIO_ONE_HOT
                        << adc_channel_in[`PIO_CH_W-1:0];        // R15
        end
    end

    // =================================================================
    // Module pin ownership outputs
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            analog_select_out <= `PIO_ZERO;
            keypad_inputs_out <= `PIO_ZERO;
        end else begin
            analog_select_out <= next_analog;                    // R15
            keypad_inputs_out <= pa_sync & keypad_irq_enables_in; // R14
        end
    end

    // =================================================================
    // Pad control cells, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < `PIO_WA; gi++) begin : g_pa
            pio_pin_cell u_cell (
                .clk_sys_in    (clk_sys_in),
                .rst_in        (rst_in),
                .latch_in      (first_port_latch[gi]),
                .dir_in        (cfg_a.dir[gi]),
                .pue_in        (cfg_a.pue[gi]),
                .hold_input_in (keypad_irq_enables_in[gi]),
                .analog_in     (1'b0),
                .pin_out       (pa_pin_out[gi]),
                .pin_oe_out    (pa_pin_oe_out[gi]),
                .pullup_out    (pa_pullup_out[gi])
            );
        end
        for (gi = 0; gi < `PIO_WB; gi++) begin : g_pb
            pio_pin_cell u_cell (
                .clk_sys_in    (clk_sys_in),
                .rst_in        (rst_in),
                .latch_in      (second_port_latch[gi]),
                .dir_in        (cfg_b.dir[gi]),
                .pue_in        (cfg_b.pue[gi]),
                .hold_input_in (1'b0),
                .analog_in     (next_analog[gi]),
                .pin_out       (pb_pin_out[gi]),
                .pin_oe_out    (pb_pin_oe_out[gi]),
                .pullup_out    (pb_pullup_out[gi])
            );
        end
        for (gi = 0; gi < `PIO_WC; gi++) begin : g_pc
            pio_pin_cell u_cell (
                .clk_sys_in    (clk_sys_in),
                .rst_in        (rst_in),
                .latch_in      (third_port_latch[gi]),
                .dir_in        (cfg_c.dir[gi]),
                .pue_in        (cfg_c.pue[gi]),
                .hold_input_in (1'b0),
                .analog_in     (1'b0),
                .pin_out       (pc_pin_out[gi]),
                .pin_oe_out    (pc_pin_oe_out[gi]),
                .pullup_out    (pc_pullup_out[gi])
            );
        end
    endgenerate

    // =================================================================
    // Checks
    dir_reset_a: assert property (@(posedge clk_sys_in)           // R3
        rst_in |=> cfg_a.dir == `PIO_ZERO && cfg_b.dir == `PIO_ZERO
                   && cfg_c.dir == `PIO_ZERO && pa_pin_oe_out == '0)
        else $error("direction not cleared by reset");

    pa_drive_a: assert property (@(posedge clk_sys_in)            // R2
        disable iff (rst_in)
        wr_in && addr_in == `PIO_OFF_A_DIR
        ##1 !wr_in && keypad_irq_enables_in == '0
        |=> pa_pin_oe_out == $past(cfg_a.dir))
        else $error("first port enable does not follow direction");

    latch_write_a: assert property (@(posedge clk_sys_in)         // R7
        disable iff (rst_in)
        wr_in && addr_in == `PIO_OFF_B_DATA
        |=> second_port_latch == $past(wdata_in))
        else $error("second port latch not written");

    pa_read_a: assert property (@(posedge clk_sys_in)             // R4
        disable iff (rst_in)
        rd_in && addr_in == `PIO_OFF_A_DATA
        |=> rdata_out == (($past(first_port_latch) & $past(cfg_a.dir))
                       | ($past(pa_pin_in, 3) & ~$past(cfg_a.dir))))
        else $error("first port read selects wrong source");

    dir_readback_a: assert property (@(posedge clk_sys_in)        // R8
        disable iff (rst_in)
        wr_in && addr_in == `PIO_OFF_C_DIR ##1 !wr_in
        ##1 rd_in && addr_in == `PIO_OFF_C_DIR
        |=> rdata_out == ($past(wdata_in, 3) & `PIO_C_MASK))
        else $error("direction read back differs from write");

    pullup_excl_a: assert property (@(posedge clk_sys_in)         // R10
        disable iff (rst_in)
        (pa_pullup_out & pa_pin_oe_out) == '0
        && (pc_pullup_out & pc_pin_oe_out) == '0)
        else $error("pullup active on a driving pin");

    pb_no_pull_a: assert property (@(posedge clk_sys_in)          // R11
        disable iff (rst_in)
        pb_pullup_out == '0)
        else $error("second port pullup turned on");

    pc_top_zero_a: assert property (@(posedge clk_sys_in)         // R18
        disable iff (rst_in)
        rd_in && (addr_in == `PIO_OFF_C_DATA
        || addr_in == `PIO_OFF_C_PUE) |=> !rdata_out[`PIO_WC])
        else $error("third port top bit reads as one");

    analog_own_a: assert property (@(posedge clk_sys_in)          // R15
        disable iff (rst_in)
        (analog_select_out & pb_pin_oe_out) == '0)
        else $error("analog pin still driven");

    keypad_gate_a: assert property (@(posedge clk_sys_in)         // R14
        disable iff (rst_in)
        ##1 (keypad_inputs_out & ~$past(keypad_irq_enables_in)) == '0)
        else $error("keypad input passed while disabled");

    rd_pulse_a: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        !rd_in |=> rdata_out == `PIO_ZERO)
        else $error("read data held past its cycle");

endmodule : pio_ports

/* File: verilog/pio_defines.svh */
// Address map, widths and reset constants of the parallel port block
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// =====================================================================
// Widths
`define PIO_AW          8
`define PIO_DW          8
`define PIO_WA          8
`define PIO_WB          8
`define PIO_WC          7
`define PIO_ADC_W       5
`define PIO_CH_W        3

// =====================================================================
// Register byte addresses
`define PIO_OFF_A_DATA  8'h00
`define PIO_OFF_B_DATA  8'h01
`define PIO_OFF_C_DATA  8'h02
`define PIO_OFF_A_DIR   8'h04
`define PIO_OFF_B_DIR   8'h05
`define PIO_OFF_C_DIR   8'h06
`define PIO_OFF_A_PUE   8'h0d
`define PIO_OFF_C_PUE   8'h0e

// =====================================================================
// Reset values and masks
`define PIO_ZERO        8'h00
`define PIO_C_MASK      8'h7f
`define PIO_ONE_HOT     8'h01
`define PIO_BIT_RST     1'b0

`endif

/* File: verilog/pio_pkg.sv */
// Shared types of the parallel port block
package pio_pkg;

    // =================================================================
    // Register select decoded from the bus address
    typedef enum logic [3:0] {
        pio_sel_none   = 4'b0000,
        pio_sel_a_data = 4'b0001,
        pio_sel_b_data = 4'b0010,
        pio_sel_c_data = 4'b0011,
        pio_sel_a_dir  = 4'b0100,
        pio_sel_b_dir  = 4'b0101,
        pio_sel_c_dir  = 4'b0110,
        pio_sel_a_pue  = 4'b0111,
        pio_sel_c_pue  = 4'b1000
    } pio_sel_e;

    // =================================================================
    // Decoded bus request
    typedef struct packed {
        pio_sel_e    sel;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } pio_req_s;

    // =================================================================
    // Per-port configuration: direction and pullup enables
    typedef struct packed {
        logic [7:0]  dir;
        logic [7:0]  pue;
    } pio_cfg_s;

endpackage : pio_pkg

/* File: verilog/pio_sync.sv */
// Two-stage synchroniser for asynchronous pin levels
`include "pio_defines.svh"

module pio_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] din_in,
    output logic      [WIDTH-1:0] dout_out
);

    logic [WIDTH-1:0] meta;

    // =================================================================
    // First stage only feeds the second to contain metastability
    always_ff @(posedge clk_sys_in) begin
        meta     <= din_in;                            // R19
        dout_out <= meta;
    end

    // =================================================================
    // Checks
    sync_delay_a: assert property (@(posedge clk_sys_in)        // R19
        disable iff (rst_in) ##2 dout_out == $past(din_in, 2))
        else $error("synchroniser output not two cycles late");

endmodule : pio_sync

/* File: verilog/pio_pin_cell.sv */
// Output driver, enable and pullup control of one port pin
`include "pio_defines.svh"

module pio_pin_cell (
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic latch_in,
    input  wire logic dir_in,
    input  wire logic pue_in,
    input  wire logic hold_input_in,
    input  wire logic analog_in,
    output logic      pin_out,
    output logic      pin_oe_out,
    output logic      pullup_out
);

    logic next_oe;
    logic next_pu;

    // =================================================================
    // Drive only when set as output and no module owns the pin
    always_comb begin
        next_oe = dir_in & ~hold_input_in & ~analog_in;      // R2 R14 R15
        next_pu = pue_in & ~dir_in & ~analog_in;             // R10
    end

    // =================================================================
    // Registered pad controls, all quiet in reset
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pin_oe_out <= `PIO_BIT_RST;
            pullup_out <= `PIO_BIT_RST;
            pin_out    <= `PIO_BIT_RST;
        end else begin
            pin_oe_out <= next_oe;                           // R2
            pullup_out <= next_pu;                           // R9
            pin_out    <= latch_in & next_oe;
        end
    end

endmodule : pio_pin_cell

/* File: testbench/pio_board.sv */
// Board model that resolves the far side of one port's pins
module pio_board #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_in,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] oe_in,
    input  wire logic [W-1:0] pullup_in,
    input  wire logic [W-1:0] drv_val_in,
    input  wire logic [W-1:0] drv_en_in,
    output logic      [W-1:0] level_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [W-1:0] last = '0;

    // =================================================================
    // Remember the wire so a floating line can toggle away from it
    always_ff @(posedge clk_sys_in) begin
        last <= level_out;
    end

    // Device drive wins, then the board, then the pullup; a floating
    // line flips every cycle so nothing reads a value by accident
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_in[i])
                level_out[i] = pin_in[i];
            else if (drv_en_in[i])
                level_out[i] = drv_val_in[i];
            else if (pullup_in[i])
                level_out[i] = 1'b1;
            else
                level_out[i] = ~last[i];
        end
    end
endmodule : pio_board

/* File: testbench/pio_ports_tb.sv */
// Self-checking testbench of the parallel port block
`include "pio_defines.svh"

module pio_ports_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_sys_in, rst_in, wr_in, rd_in;
    logic [7:0] addr_in, wdata_in, rdata_out;
    logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe_out, pa_pullup_out;
    logic [7:0] pb_pin_in, pb_pin_out, pb_pin_oe_out, pb_pullup_out;
    logic [6:0] pc_pin_in, pc_pin_out, pc_pin_oe_out, pc_pullup_out;
    logic [7:0] keypad_irq_enables_in, keypad_inputs_out;
    logic [7:0] analog_select_out, ba, bb, en, sel;
    logic [6:0] bc;
    logic [4:0] adc_channel_in, ch;
    logic [7:0] la, da, ua, lb, db, lc, dc, uc, ka;
    int         error_cnt = 0;
    int         checks = 0;
    int         cyc = 0;

    pio_ports i_pio_ports (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .pa_pin_in(pa_pin_in),
        .pa_pin_out(pa_pin_out), .pa_pin_oe_out(pa_pin_oe_out),
        .pa_pullup_out(pa_pullup_out), .pb_pin_in(pb_pin_in),
        .pb_pin_out(pb_pin_out), .pb_pin_oe_out(pb_pin_oe_out),
        .pb_pullup_out(pb_pullup_out), .pc_pin_in(pc_pin_in),
        .pc_pin_out(pc_pin_out), .pc_pin_oe_out(pc_pin_oe_out),
        .pc_pullup_out(pc_pullup_out),
        .keypad_irq_enables_in(keypad_irq_enables_in),
        .keypad_inputs_out(keypad_inputs_out),
        .adc_channel_in(adc_channel_in),
        .analog_select_out(analog_select_out)
    );

    // =================================================================
    // Board side of each port
    pio_board #(.W(8)) i_board_a (.clk_sys_in(clk_sys_in),
        .pin_in(pa_pin_out), .oe_in(pa_pin_oe_out), .pullup_in(pa_pullup_out),
        .drv_val_in(ba), .drv_en_in(en), .level_out(pa_pin_in));
    pio_board #(.W(8)) i_board_b (.clk_sys_in(clk_sys_in),
        .pin_in(pb_pin_out), .oe_in(pb_pin_oe_out), .pullup_in(pb_pullup_out),
        .drv_val_in(bb), .drv_en_in(en), .level_out(pb_pin_in));
    pio_board #(.W(7)) i_board_c (.clk_sys_in(clk_sys_in),
        .pin_in(pc_pin_out), .oe_in(pc_pin_oe_out), .pullup_in(pc_pullup_out),
        .drv_val_in(bc), .drv_en_in(en[6:0]), .level_out(pc_pin_in));

    // =================================================================
    // Clock and hang guard; the sequence needs about 1000 cycles
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("[FAIL] timeout expected end seen cycle %0d", cyc);
            close_out();
        end
    end

    // Expected data read: latch for outputs, pin level for inputs
    function automatic logic [7:0] mix(input logic [7:0] l, d, b);
        return (l & d) | (b & ~d);
    endfunction : mix
    // Channel codes above seven select no pin
    function automatic logic [7:0] chsel(input logic [4:0] c);
        return (c < 5'h08) ? (8'h01 << c) : 8'h00;
    endfunction : chsel
    // Corner values first, then random ones
    function automatic logic [7:0] pick(input int i);
        return (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
    endfunction : pick

    task automatic chk(input string what, input logic [7:0] exp, got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : bus_wr
    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, exp, input string what);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        chk(what, exp, rdata_out);
    endtask : bus_rd
    // Covers the register stage plus the pin synchroniser
    task automatic settle();
        repeat (4) @(posedge clk_sys_in);
        #1;
    endtask : settle
    task automatic close_out();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // =================================================================
    // Main sequence
    initial begin
        void'($urandom(32'h48da));
        {rst_in, wr_in, rd_in, addr_in, wdata_in} = {1'b1, 18'h0};
        {ba, bb, bc, en, keypad_irq_enables_in, adc_channel_in} = '0;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        // Reset state and an unmapped place
        bus_rd(`PIO_OFF_A_DIR, 8'h00, "a_dir_rst");
        bus_rd(`PIO_OFF_B_DIR, 8'h00, "b_dir_rst");
        bus_rd(`PIO_OFF_C_DIR, 8'h00, "c_dir_rst");
        bus_rd(`PIO_OFF_A_PUE, 8'h00, "a_pue_rst");
        bus_rd(`PIO_OFF_C_PUE, 8'h00, "c_pue_rst");
        chk("oe_rst", 8'h00, pa_pin_oe_out | pb_pin_oe_out);
        bus_wr(8'h03, 8'hff);
        bus_rd(8'h03, 8'h00, "unmapped");
        // Random configurations with the board driving every pin
        for (int i = 0; i < 24; i++) begin
            {la, da, ua, lb, db} = {pick(i), pick(i), pick(i), pick(i), pick(i)};
            {lc, dc, uc, ka} = {pick(i), pick(i), pick(i), pick(i)};
            ch = (i == 1) ? 5'h07 : (i == 2) ? 5'h08 : 5'($urandom);
            @(posedge clk_sys_in);
            {ba, bb, bc} <= 23'($urandom);
            en <= 8'hff;
            keypad_irq_enables_in <= ka;
            adc_channel_in <= ch;
            bus_wr(`PIO_OFF_A_DATA, la);
            bus_wr(`PIO_OFF_A_DIR, da);
            bus_wr(`PIO_OFF_A_PUE, ua);
            bus_wr(`PIO_OFF_B_DATA, lb);
            bus_wr(`PIO_OFF_B_DIR, db);
            bus_wr(`PIO_OFF_C_DATA, lc);
            bus_wr(`PIO_OFF_C_DIR, dc);
            bus_rd(`PIO_OFF_C_DIR, dc & 8'h7f, "c_dir");
            bus_wr(`PIO_OFF_C_PUE, uc);
            settle();
            sel = chsel(ch);
            chk("pa_oe", da & ~ka, pa_pin_oe_out);
            chk("pa_drv", la & da & ~ka, pa_pin_out);
            chk("pa_pu", ua & ~da, pa_pullup_out);
            chk("keypad", ba & ka, keypad_inputs_out);
            chk("an_sel", sel, analog_select_out);
            chk("pb_oe", db & ~sel, pb_pin_oe_out);
            chk("pb_drv", lb & db & ~sel, pb_pin_out);
            chk("pb_pu", 8'h00, pb_pullup_out);
            chk("pc_oe", dc & 8'h7f, {1'b0, pc_pin_oe_out});
            chk("pc_drv", lc & dc & 8'h7f, {1'b0, pc_pin_out});
            chk("pc_pu", uc & ~dc & 8'h7f, {1'b0, pc_pullup_out});
            bus_rd(`PIO_OFF_A_DATA, mix(la, da, ba), "a_data");
            bus_rd(`PIO_OFF_B_DATA, mix(lb, db, bb), "b_data");
            bus_rd(`PIO_OFF_C_DATA, mix(lc, dc, {1'b0, bc}) & 8'h7f,
                   "c_data");
            bus_rd(`PIO_OFF_A_DIR, da, "a_dir");
            bus_rd(`PIO_OFF_B_DIR, db, "b_dir");
            bus_rd(`PIO_OFF_A_PUE, ua, "a_pue");
            bus_rd(`PIO_OFF_C_PUE, uc & 8'h7f, "c_pue");
        end
        // Board lets go: inputs with pullups read high
        @(posedge clk_sys_in);
        en <= 8'h00;
        keypad_irq_enables_in <= 8'h00;
        adc_channel_in <= 5'h1f;
        bus_wr(`PIO_OFF_A_DIR, 8'h00);
        bus_wr(`PIO_OFF_C_DIR, 8'h00);
        bus_wr(`PIO_OFF_A_PUE, 8'hff);
        bus_wr(`PIO_OFF_C_PUE, 8'hff);
        settle();
        bus_rd(`PIO_OFF_A_DATA, 8'hff, "a_pulled");
        bus_rd(`PIO_OFF_C_DATA, 8'h7f, "c_pulled");
        bus_wr(`PIO_OFF_A_DIR, 8'h0f);
        settle();
        chk("pa_pu_out", 8'hf0, pa_pullup_out);
        // Latches survive a reset in mid-run, configuration does not
        bus_wr(`PIO_OFF_A_DATA, 8'h5a);
        bus_wr(`PIO_OFF_B_DATA, 8'ha5);
        bus_wr(`PIO_OFF_C_DATA, 8'hc3);
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        bus_rd(`PIO_OFF_A_DIR, 8'h00, "a_dir_rst2");
        bus_rd(`PIO_OFF_A_PUE, 8'h00, "a_pue_rst2");
        chk("pa_pu_rst", 8'h00, pa_pullup_out);
        bus_wr(`PIO_OFF_A_DIR, 8'hff);
        bus_wr(`PIO_OFF_B_DIR, 8'hff);
        bus_wr(`PIO_OFF_C_DIR, 8'hff);
        bus_rd(`PIO_OFF_A_DATA, 8'h5a, "a_kept");
        bus_rd(`PIO_OFF_B_DATA, 8'ha5, "b_kept");
        bus_rd(`PIO_OFF_C_DATA, 8'h43, "c_kept");
        close_out();
    end
endmodule : pio_ports_tb
